//--- hw/rsc_regs.vh
// Constants for the 8-bit RISC core datapath: phases, encodings, file map, ALU codes.
// Assumes inclusion by bare name from every design file of the core.
// Operation
// RULE_01 - Instructions arrive over a program bus kept apart from the data bus, so fetch and data access overlap.
// RULE_02 - Each instruction is one 12-bit word delivered whole in one instruction cycle.
// RULE_03 - A two-stage pipeline fetches the next word while the current one executes.
// RULE_04 - Every instruction except a program branch completes in one instruction cycle.
// RULE_05 - A program branch takes two instruction cycles because the prefetched word is discarded.
// RULE_06 - The core addresses an internal program store of 512 words of 12 bits with no external program bus.
// RULE_07 - Special registers, the program counter among them, sit in the data space and are reachable directly and indirectly.
// RULE_08 - Any operation applies to any register under any addressing mode.
// RULE_09 - The ALU is 8 bits wide and adds, subtracts, shifts and performs bitwise logic.
// RULE_10 - Arithmetic treats operands as two's complement values.
// RULE_11 - Two-operand instructions take the accumulator and either a file register or an immediate.
// RULE_12 - Single-operand instructions work on the accumulator or a file register.
// RULE_13 - The accumulator is an 8-bit ALU register that has no data address.
// RULE_14 - The ALU updates carry, nibble overflow and zero flags in the status register as the instruction demands.
// RULE_15 - In subtraction carry is an inverted borrow and the nibble overflow bit an inverted low-nibble borrow.
// RULE_16 - The clock is split into four phases; the PC advances in phase one and the word is latched in phase four.
// RULE_17 - The zero flag is set for an all-zero result and cleared otherwise.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// Phase counter codes.
`define RSC_PH_ONE 2'h0
`define RSC_PH_FOUR 2'h3

// Reset values and fixed words.
`define RSC_PC_RESET 9'h000
`define RSC_NOP_WORD 12'h000
`define RSC_BYTE_ZERO 8'h00

// Data space map, 5-bit file addresses.
`define RSC_F_INDIRECT 5'h00
`define RSC_F_PCL 5'h02
`define RSC_F_STATUS 5'h03
`define RSC_F_FSR 5'h04
`define RSC_F_PORT_IN 5'h05
`define RSC_F_PORT_OUT 5'h06

// Status bit positions.
`define RSC_ST_C 0
`define RSC_ST_NOV 1
`define RSC_ST_Z 2

// Instruction groups in ir[11:10].
`define RSC_G_FILE 2'h0
`define RSC_G_BIT 2'h1
`define RSC_G_FLOW 2'h2
`define RSC_G_LIT 2'h3

// File group operations in ir[9:6].
`define RSC_F_MOVWF 4'h0
`define RSC_F_CLR 4'h1
`define RSC_F_SUB 4'h2
`define RSC_F_DEC 4'h3
`define RSC_F_IOR 4'h4
`define RSC_F_AND 4'h5
`define RSC_F_XOR 4'h6
`define RSC_F_ADD 4'h7
`define RSC_F_MOV 4'h8
`define RSC_F_COM 4'h9
`define RSC_F_INC 4'hA
`define RSC_F_DECSZ 4'hB
`define RSC_F_RR 4'hC
`define RSC_F_RL 4'hD
`define RSC_F_SWAP 4'hE
`define RSC_F_INCSZ 4'hF

// ALU operation codes.
`define RSC_A_ADD 4'h0
`define RSC_A_SUB 4'h1
`define RSC_A_AND 4'h2
`define RSC_A_IOR 4'h3
`define RSC_A_XOR 4'h4
`define RSC_A_PASSB 4'h5
`define RSC_A_COM 4'h6
`define RSC_A_INC 4'h7
`define RSC_A_DEC 4'h8
`define RSC_A_RR 4'h9
`define RSC_A_RL 4'hA
`define RSC_A_SWAP 4'hB
`define RSC_A_CLR 4'hC

`endif

//--- hw/rsc_alu.v
// 8-bit ALU of the core: arithmetic, logic, shifts and flag results.
// Assumes the caller decides which flags are actually written back.
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_alu #(
    parameter WIDTH = 8
) (
    input wire [3:0] op_in, // Operation code.
    input wire [WIDTH-1:0] a_in, // Accumulator or mask operand.
    input wire [WIDTH-1:0] b_in, // File register or immediate operand.
    input wire carry_in, // Carry flag for rotates.
    output reg [WIDTH-1:0] y_out, // Result.
    output reg carry_out, // Carry, inverted borrow in subtraction.
    output reg nov_out, // Nibble overflow, inverted low-nibble borrow.
    output wire zero_out // Result is all zero.
);

    reg [WIDTH:0] sum;
    reg [4:0] low;

    // Subtraction is b plus the complement of a plus one, so carry out is naturally an inverted borrow.
    always @* begin
        sum = {(WIDTH+1){1'b0}};
        low = 5'h00;
        y_out = b_in;
        carry_out = carry_in;
        nov_out = 1'b0;
        case (op_in)
            `RSC_A_ADD: begin // RULE_09 RULE_10
                sum = {1'b0, a_in} + {1'b0, b_in};
                low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
                y_out = sum[WIDTH-1:0];
                carry_out = sum[WIDTH];
                nov_out = low[4];
            end
            `RSC_A_SUB: begin // RULE_15
                sum = {1'b0, b_in} + {1'b0, ~a_in} + {{WIDTH{1'b0}}, 1'b1};
                low = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
                y_out = sum[WIDTH-1:0];
                carry_out = sum[WIDTH];
                nov_out = low[4];
            end
            `RSC_A_AND: y_out = a_in & b_in;
            `RSC_A_IOR: y_out = a_in | b_in;
            `RSC_A_XOR: y_out = a_in ^ b_in;
            `RSC_A_PASSB: y_out = b_in;
            `RSC_A_COM: y_out = ~b_in;
            `RSC_A_INC: y_out = b_in + {{(WIDTH-1){1'b0}}, 1'b1};
            `RSC_A_DEC: y_out = b_in - {{(WIDTH-1){1'b0}}, 1'b1};
            `RSC_A_RR: begin // RULE_09
                y_out = {carry_in, b_in[WIDTH-1:1]};
                carry_out = b_in[0];
            end
            `RSC_A_RL: begin
                y_out = {b_in[WIDTH-2:0], carry_in};
                carry_out = b_in[WIDTH-1];
            end
            `RSC_A_SWAP: y_out = {b_in[3:0], b_in[7:4]};
            `RSC_A_CLR: y_out = {WIDTH{1'b0}};
            default: y_out = b_in;
        endcase
    end

    // Zero is a plain reduction so every affecting instruction sees the same test.
    assign zero_out = (y_out == {WIDTH{1'b0}}); // RULE_17

endmodule // rsc_alu

//--- hw/rsc_core.v
// Four-phase 8-bit RISC core with internal program store, file registers and accumulator.
// Assumes program loading and the port input come from outside; the port input is synchronised here.
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_core #(
    parameter PROG_DEPTH = 512,
    parameter PADDR_W = 9,
    parameter FILE_DEPTH = 32
) (
    input wire clk_in, // Device clock, 125 MHz.
    input wire resetn_in, // Asynchronous reset, active low.
    input wire prog_we_in, // Program store write strobe, same clock.
    input wire [PADDR_W-1:0] prog_addr_in, // Program store write address.
    input wire [11:0] prog_data_in, // Program store write word.
    input wire [7:0] port_in, // Asynchronous input port pins.
    output reg [7:0] port_out, // Output port register.
    output reg [PADDR_W-1:0] pc_out, // Program counter.
    output reg [7:0] acc_out, // Accumulator.
    output reg [7:0] status_out, // Status register.
    output reg phase_one_out // High during phase one.
);

    // Program store and general file registers.
    reg [11:0] prog_mem [0:PROG_DEPTH-1];
    reg [7:0] file_ram [0:FILE_DEPTH-1];
    reg [1:0] phase;
    reg [11:0] ir;
    reg hold;
    reg [7:0] fsr;
    reg [PADDR_W-1:0] stack0;
    reg [PADDR_W-1:0] stack1;
    reg [7:0] port_meta;
    reg [7:0] port_sync;

    // Decoded fields.
    wire [1:0] grp = ir[11:10];
    wire [3:0] fop = ir[9:6];
    wire dest_file = ir[5];
    wire [2:0] bit_sel = ir[7:5];
    wire [7:0] lit = ir[7:0];
    wire [4:0] faddr = (ir[4:0] == `RSC_F_INDIRECT) ? fsr[4:0] : ir[4:0];
    wire ind_null = (ir[4:0] == `RSC_F_INDIRECT) && (fsr[4:0] == `RSC_F_INDIRECT);
    wire [7:0] bit_mask = 8'h01 << bit_sel;

    reg [7:0] fval;
    reg [3:0] alu_op;
    reg [7:0] alu_a;
    reg [7:0] alu_b;
    wire [7:0] alu_y;
    wire alu_c;
    wire alu_nov;
    wire alu_z;

    // Read of the data space; indirect addressing reaches every special register too.
    always @* begin
        case (faddr)
            `RSC_F_INDIRECT: fval = `RSC_BYTE_ZERO;
            `RSC_F_PCL: fval = pc_out[7:0]; // RULE_07
            `RSC_F_STATUS: fval = status_out;
            `RSC_F_FSR: fval = fsr;
            `RSC_F_PORT_IN: fval = port_sync;
            `RSC_F_PORT_OUT: fval = port_out;
            default: fval = file_ram[faddr];
        endcase
        if (ind_null) begin
            fval = `RSC_BYTE_ZERO;
        end
    end

    // Operand selection: accumulator or bit mask on one side, file register or immediate on the other.
    always @* begin
        alu_a = acc_out; // RULE_11
        alu_b = fval; // RULE_12
        alu_op = `RSC_A_PASSB;
        case (grp)
            `RSC_G_FILE: begin
                case (fop)
                    `RSC_F_MOVWF: begin
                        alu_b = acc_out; // Storing the accumulator passes it through the b side.
                    end
                    `RSC_F_CLR: alu_op = `RSC_A_CLR;
                    `RSC_F_SUB: alu_op = `RSC_A_SUB;
                    `RSC_F_DEC: alu_op = `RSC_A_DEC;
                    `RSC_F_DECSZ: alu_op = `RSC_A_DEC;
                    `RSC_F_IOR: alu_op = `RSC_A_IOR;
                    `RSC_F_AND: alu_op = `RSC_A_AND;
                    `RSC_F_XOR: alu_op = `RSC_A_XOR;
                    `RSC_F_ADD: alu_op = `RSC_A_ADD;
                    `RSC_F_COM: alu_op = `RSC_A_COM;
                    `RSC_F_INC: alu_op = `RSC_A_INC;
                    `RSC_F_INCSZ: alu_op = `RSC_A_INC;
                    `RSC_F_RR: alu_op = `RSC_A_RR;
                    `RSC_F_RL: alu_op = `RSC_A_RL;
                    `RSC_F_SWAP: alu_op = `RSC_A_SWAP;
                    default: alu_op = `RSC_A_PASSB;
                endcase
            end
            `RSC_G_BIT: begin
                alu_a = ir[8] ? bit_mask : ~bit_mask;
                alu_op = ir[8] ? `RSC_A_IOR : `RSC_A_AND;
            end
            `RSC_G_LIT: begin
                alu_b = lit;
                case (ir[9:8])
                    2'h1: alu_op = `RSC_A_IOR;
                    2'h2: alu_op = `RSC_A_AND;
                    2'h3: alu_op = `RSC_A_XOR;
                    default: alu_op = `RSC_A_PASSB;
                endcase
            end
            default: alu_b = lit;
        endcase
    end

    rsc_alu #(
        .WIDTH(8)
    ) u_alu (
        .op_in(alu_op),
        .a_in(alu_a),
        .b_in(alu_b),
        .carry_in(status_out[`RSC_ST_C]),
        .y_out(alu_y),
        .carry_out(alu_c),
        .nov_out(alu_nov),
        .zero_out(alu_z)
    );

    // Write-back and flow decisions for the instruction now in execution.
    reg wr_file;
    reg wr_acc;
    reg upd_z;
    reg upd_cn;
    reg upd_c;
    reg do_jump;
    reg do_skip;
    reg do_call;
    reg do_ret;
    reg [PADDR_W-1:0] jump_to;
    always @* begin
        wr_file = 1'b0;
        wr_acc = 1'b0;
        upd_z = 1'b0;
        upd_cn = 1'b0;
        upd_c = 1'b0;
        do_jump = 1'b0;
        do_skip = 1'b0;
        do_call = 1'b0;
        do_ret = 1'b0;
        jump_to = pc_out;
        case (grp)
            `RSC_G_FILE: begin
                wr_file = (fop == `RSC_F_MOVWF) ? dest_file : dest_file;
                wr_acc = (fop != `RSC_F_MOVWF) && !dest_file;
                upd_z = (fop != `RSC_F_MOVWF) && (fop != `RSC_F_RR) && (fop != `RSC_F_RL) &&
                    (fop != `RSC_F_SWAP) && (fop != `RSC_F_DECSZ) && (fop != `RSC_F_INCSZ); // RULE_14
                upd_cn = (fop == `RSC_F_ADD) || (fop == `RSC_F_SUB); // RULE_14
                upd_c = (fop == `RSC_F_RR) || (fop == `RSC_F_RL);
                do_skip = ((fop == `RSC_F_DECSZ) || (fop == `RSC_F_INCSZ)) && alu_z;
            end
            `RSC_G_BIT: begin
                wr_file = !ir[9]; // RULE_08
                do_skip = ir[9] && ((fval[bit_sel] ^ ir[8]) == 1'b0);
            end
            `RSC_G_FLOW: begin
                case (ir[9:8])
                    2'h0: begin
                        do_ret = 1'b1;
                        wr_acc = 1'b1;
                        jump_to = stack0;
                    end
                    2'h1: begin
                        do_call = 1'b1;
                        jump_to = {1'b0, lit};
                    end
                    default: jump_to = ir[PADDR_W-1:0];
                endcase
                do_jump = 1'b1; // RULE_05
            end
            `RSC_G_LIT: begin
                wr_acc = 1'b1;
                upd_z = (ir[9:8] != 2'h0);
            end
            default: wr_acc = 1'b0;
        endcase
        if (wr_file && (faddr == `RSC_F_PCL) && !ind_null) begin
            do_jump = 1'b1; // RULE_07
            jump_to = {1'b0, alu_y};
        end
    end

    // Program store writes come from the loader; the core only reads it.
    always @(posedge clk_in) begin
        if (prog_we_in) begin
            prog_mem[prog_addr_in] <= prog_data_in; // RULE_06
        end
    end

    // General file registers; special addresses are held in their own flops.
    always @(posedge clk_in) begin
        if ((phase == `RSC_PH_FOUR) && wr_file && !ind_null) begin
            file_ram[faddr] <= alu_y;
        end
    end

    // The port input is asynchronous, so it passes two flops before the data space sees it.
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_meta <= `RSC_BYTE_ZERO;
            port_sync <= `RSC_BYTE_ZERO;
        end else begin
            port_meta <= port_in;
            port_sync <= port_meta;
        end
    end

    // Four-phase sequencer, fetch and execute. Execution and the next fetch both land in phase four,
    // and they use separate buses, so neither stalls the other.
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase <= `RSC_PH_ONE;
            phase_one_out <= 1'b1;
            pc_out <= `RSC_PC_RESET;
            ir <= `RSC_NOP_WORD;
            hold <= 1'b1;
            acc_out <= `RSC_BYTE_ZERO;
            status_out <= `RSC_BYTE_ZERO;
            fsr <= `RSC_BYTE_ZERO;
            port_out <= `RSC_BYTE_ZERO;
            stack0 <= `RSC_PC_RESET;
            stack1 <= `RSC_PC_RESET;
        end else begin
            phase <= phase + 2'h1; // RULE_16
            phase_one_out <= (phase == `RSC_PH_FOUR);
            if (phase == `RSC_PH_ONE) begin
                if (!hold) begin
                    pc_out <= pc_out + {{(PADDR_W-1){1'b0}}, 1'b1}; // RULE_16
                end
                hold <= 1'b0;
            end
            if (phase == `RSC_PH_FOUR) begin
                // A taken branch or skip replaces the prefetched word with a no-op.
                if (do_jump || do_skip) begin
                    ir <= `RSC_NOP_WORD; // RULE_05
                end else begin
                    ir <= prog_mem[pc_out]; // RULE_01 RULE_02 RULE_03 RULE_04
                end
                if (do_jump) begin
                    pc_out <= jump_to;
                    hold <= 1'b1; // RULE_05
                end
                if (do_call) begin
                    stack0 <= pc_out;
                    stack1 <= stack0;
                end
                if (do_ret) begin
                    stack0 <= stack1;
                end
                if (wr_acc) begin
                    acc_out <= alu_y; // RULE_13
                end
                if (wr_file && !ind_null) begin
                    if (faddr == `RSC_F_FSR) begin
                        fsr <= alu_y;
                    end
                    if (faddr == `RSC_F_PORT_OUT) begin
                        port_out <= alu_y;
                    end
                end
                // Flag results from the ALU take priority over a direct write to the status register.
                status_out <= {5'h00,
                    upd_z ? alu_z : ((wr_file && faddr == `RSC_F_STATUS && !ind_null) ?
                        alu_y[`RSC_ST_Z] : status_out[`RSC_ST_Z]), // RULE_17
                    upd_cn ? alu_nov : ((wr_file && faddr == `RSC_F_STATUS && !ind_null) ?
                        alu_y[`RSC_ST_NOV] : status_out[`RSC_ST_NOV]), // RULE_15
                    (upd_cn || upd_c) ? alu_c : ((wr_file && faddr == `RSC_F_STATUS && !ind_null) ?
                        alu_y[`RSC_ST_C] : status_out[`RSC_ST_C])}; // RULE_14
            end
        end
    end

endmodule // rsc_core

//--- sim/rsc_core_assertions.sv
// Concurrent checks on the ports of the four-phase core.
// Assumes one clock domain and binding to every rsc_core instance.
`timescale 1ns/100ps

module rsc_core_assertions #(
    parameter PADDR_W = 9
) (
    input wire clk_in, // Device clock.
    input wire resetn_in, // Asynchronous reset, active low.
    input wire [7:0] port_out, // Output port register.
    input wire [PADDR_W-1:0] pc_out, // Program counter.
    input wire [7:0] acc_out, // Accumulator.
    input wire [7:0] status_out, // Status register.
    input wire phase_one_out // Phase one marker.
);
    // All checks share one clock and are silenced during reset.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Phase one recurs every fourth clock.
    a_phase_cycle: assert property (phase_one_out |=> !phase_one_out [*3] ##1 phase_one_out)
        else $error("phase one marker out of step");
    // The counter moves only at the phase one or phase four edge.
    a_pc_phase: assert property ($changed(pc_out) |-> $fell(phase_one_out) || $rose(phase_one_out))
        else $error("program counter moved mid cycle");
    // A move at the phase one edge is a plain increment.
    a_pc_step: assert property ($fell(phase_one_out) && $changed(pc_out) |-> pc_out == $past(pc_out) + 1'b1)
        else $error("program counter step is not one");
    // After the phase one edge the counter holds through phases two and three.
    a_pc_rate: assert property ($fell(phase_one_out) |=> $stable(pc_out) [*2])
        else $error("program counter moved twice in a cycle");
    // A branch holds the counter for the whole discarded cycle.
    a_branch_hold: assert property ($rose(phase_one_out) && $changed(pc_out) |=> $stable(pc_out) [*4])
        else $error("branch target not held for one cycle");
    // Results land only at the phase four edge.
    a_acc_moment: assert property ($changed(acc_out) |-> $rose(phase_one_out))
        else $error("accumulator changed off the phase four edge");
    a_port_moment: assert property (!$rose(phase_one_out) |-> $stable(port_out))
        else $error("output port changed off the phase four edge");
    a_status_moment: assert property ($changed(status_out) |-> phase_one_out)
        else $error("status changed off the phase four edge");
    // Only carry, nibble overflow and zero exist in the status byte.
    a_status_zero: assert property (status_out[7:3] == 5'h00)
        else $error("unused status bits set");
endmodule // rsc_core_assertions

bind rsc_core rsc_core_assertions #(.PADDR_W(PADDR_W)) rsc_core_assertions_i (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .port_out(port_out),
    .pc_out(pc_out),
    .acc_out(acc_out),
    .status_out(status_out),
    .phase_one_out(phase_one_out)
);

//--- sim/rsc_core_tb_top.sv
// Self-checking bench for the core: ALU table, branch timing, file map.
// Assumes the checker is bound in and the header is on the include path.
`timescale 1ns/100ps
`include "rsc_regs.vh"

module rsc_core_tb_top;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic prog_we_in = 1'b0;
    logic [8:0] prog_addr_in = 9'h000;
    logic [11:0] prog_data_in = 12'h000;
    logic [7:0] port_in = 8'h3C;
    wire [7:0] port_out;
    wire [7:0] acc_out;
    wire [7:0] status_out;
    wire [8:0] pc_out;
    wire phase_one_out;
    logic [11:0] img [0:15];
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    rsc_core rsc_core_i (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .prog_we_in(prog_we_in),
        .prog_addr_in(prog_addr_in),
        .prog_data_in(prog_data_in),
        .port_in(port_in),
        .port_out(port_out),
        .pc_out(pc_out),
        .acc_out(acc_out),
        .status_out(status_out),
        .phase_one_out(phase_one_out)
    );

    // Free-running 125 MHz clock.
    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // Hang guard; the whole run needs well under two thousand cycles.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic complete_run();
        begin
            $display("comparisons %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    // Loads the image under reset, releases, and times the first port write.
    // Reset is held across the load so the core never fetches a half-written store.
    task automatic run_img(input int n, output int lat);
        int i;
        begin
            @(posedge clk_in);
            resetn_in <= 1'b0;
            for (i = 0; i < n; i++) begin
                @(posedge clk_in);
                prog_we_in <= 1'b1;
                prog_addr_in <= i[8:0];
                prog_data_in <= img[i];
            end
            @(posedge clk_in);
            prog_we_in <= 1'b0;
            repeat (5) @(posedge clk_in);
            resetn_in <= 1'b1;
            lat = 0;
            for (i = 1; i <= 64; i++) begin
                @(posedge clk_in);
                #1;
                if (lat == 0 && port_out !== 8'h00) lat = i;
            end
        end
    endtask

    // Two operands: file 0x08 holds f, accumulator holds a, result goes to the accumulator.
    task automatic alu_case(input logic [3:0] op, input logic [7:0] a, input logic [7:0] f,
                            input logic [7:0] ex_acc, input logic [7:0] ex_st);
        int lat;
        begin
            img[0] = {4'hC, f};
            img[1] = 12'h028;
            img[2] = {4'hC, a};
            img[3] = {2'b00, op, 6'h08};
            img[4] = 12'hA04;
            run_img(5, lat);
            check(acc_out, ex_acc);
            check(status_out, ex_st);
        end
    endtask

    task automatic test_alu();
        begin
            alu_case(`RSC_F_ADD, 8'h01, 8'h0F, 8'h10, 8'h02);
            alu_case(`RSC_F_ADD, 8'h01, 8'hFF, 8'h00, 8'h07);
            alu_case(`RSC_F_SUB, 8'h06, 8'h05, 8'hFF, 8'h00);
            alu_case(`RSC_F_SUB, 8'h01, 8'h10, 8'h0F, 8'h01);
            alu_case(`RSC_F_SUB, 8'h03, 8'h03, 8'h00, 8'h07);
            alu_case(`RSC_F_AND, 8'h3C, 8'hF0, 8'h30, 8'h00);
            alu_case(`RSC_F_IOR, 8'h00, 8'h00, 8'h00, 8'h04);
            alu_case(`RSC_F_XOR, 8'h0F, 8'hA5, 8'hAA, 8'h00);
            alu_case(`RSC_F_RR, 8'h55, 8'h03, 8'h01, 8'h01);
            alu_case(`RSC_F_RL, 8'h55, 8'h81, 8'h02, 8'h01);
            alu_case(`RSC_F_COM, 8'h55, 8'h00, 8'hFF, 8'h00);
            alu_case(`RSC_F_SWAP, 8'h55, 8'h3C, 8'hC3, 8'h00);
            alu_case(`RSC_F_DEC, 8'h55, 8'h01, 8'h00, 8'h04);
            alu_case(`RSC_F_INC, 8'h55, 8'hFF, 8'h00, 8'h04);
            alu_case(`RSC_F_MOV, 8'h55, 8'h00, 8'h00, 8'h04);
            $display("test alu done");
        end
    endtask

    // A plain program writes the port at edge 12; a leading goto costs two extra instruction cycles, so edge 20.
    task automatic test_branch();
        int lat;
        begin
            img[0] = 12'hC22;
            img[1] = 12'h026;
            img[2] = 12'hA02;
            run_img(3, lat);
            check(lat[7:0], 8'h0C);
            check(port_out, 8'h22);
            img[0] = 12'hA05;
            img[1] = 12'hC11;
            img[2] = 12'h026;
            img[3] = 12'hA03;
            img[4] = 12'h000;
            img[5] = 12'hC22;
            img[6] = 12'h026;
            img[7] = 12'hA07;
            run_img(8, lat);
            check(lat[7:0], 8'h14);
            check(port_out, 8'h22);
            check(acc_out, 8'h22);
            check(pc_out[7:0], 8'h07);
            check({7'h00, phase_one_out}, 8'h01);
            $display("test branch done");
        end
    endtask

    // Indirect store, direct reload, a branch by writing the pc low byte, then a port read.
    task automatic test_file();
        int lat;
        begin
            img[0] = 12'hC0A;
            img[1] = 12'h024;
            img[2] = 12'hC5A;
            img[3] = 12'h020;
            img[4] = 12'hC00;
            img[5] = 12'h20A;
            img[6] = 12'h026;
            img[7] = 12'hC0B;
            img[8] = 12'h022;
            img[9] = 12'hC11;
            img[10] = 12'h026;
            img[11] = 12'h205;
            img[12] = 12'hA0C;
            run_img(13, lat);
            check(lat[7:0], 8'h20);
            check(port_out, 8'h5A);
            check(acc_out, 8'h3C);
            check(status_out, 8'h00);
            $display("test file done");
        end
    endtask

    // A call into a bit set and a taken skip, then a return literal merged with the port.
    // Only a taken skip leaves bit 7 of the port set, so the final byte shows the skip.
    task automatic test_flow();
        int lat;
        int i;
        begin
            img[0] = 12'h908;
            img[1] = 12'h106;
            img[2] = 12'h026;
            img[3] = 12'hA03;
            for (i = 4; i < 8; i++) begin
                img[i] = 12'h000;
            end
            img[8] = 12'h5E6;
            img[9] = 12'h7E6;
            img[10] = 12'h4E6;
            img[11] = 12'h825;
            run_img(12, lat);
            check(lat[7:0], 8'h10);
            check(acc_out, 8'hA5);
            check(port_out, 8'hA5);
            check(status_out, 8'h00);
            $display("test flow done");
        end
    endtask

    // Main sequence.
    initial begin
        test_alu();
        test_branch();
        test_file();
        test_flow();
        complete_run();
    end
endmodule // rsc_core_tb_top
